/* pesr_pkg.sv */
package pesr_pkg;

  // Command opcodes seen on the serial link
  localparam logic [7:0] OPC_SUSPEND  = 8'h75;
  localparam logic [7:0] OPC_RESUME   = 8'h7A;
  localparam logic [7:0] OPC_CHIP_A   = 8'h60;
  localparam logic [7:0] OPC_CHIP_B   = 8'hC7;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32 = 8'h52;
  localparam logic [7:0] OPC_ERASE_64 = 8'hD8;
  localparam logic [7:0] OPC_PROGRAM  = 8'h02;
  localparam logic [7:0] OPC_WREN     = 8'h06;
  localparam logic [7:0] OPC_WRDI     = 8'h04;
  localparam logic [7:0] OPC_WRSR     = 8'h01;
  localparam logic [7:0] OPC_RDSR     = 8'h05;

  // Frame lengths in whole bytes, opcode included
  localparam logic [2:0] PROG_MIN_BYTES  = 3'h5;
  localparam logic [2:0] ERASE_MIN_BYTES = 3'h4;
  localparam logic [2:0] NBYTES_MAX      = 3'h5;

  // Region masks: bits that select a page or block
  localparam logic [23:0] MASK_PAGE = 24'hFFFF00;
  localparam logic [23:0] MASK_4K   = 24'hFFF000;
  localparam logic [23:0] MASK_32K  = 24'hFF8000;
  localparam logic [23:0] MASK_64K  = 24'hFF0000;

  // Timing: settle time after a resume, in ns and in cycles
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned RESUME_SETTLE_NS  = 1000;
  localparam int unsigned RESUME_SETTLE_CYC =
    (RESUME_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SPAN_PAGE, SPAN_4K, SPAN_32K, SPAN_64K}
    pesr_span_t;
  typedef enum logic [1:0] {KIND_NONE, KIND_PROG, KIND_BERASE, KIND_CERASE}
    pesr_kind_t;
  typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_CHIP, ST_PROG_ES}
    pesr_state_t;
  typedef enum {ACT_NONE, ACT_SUSPEND, ACT_RESUME_P, ACT_RESUME_E,
                ACT_START_P, ACT_START_E, ACT_START_C, ACT_ABORT,
                ACT_IGNORE, ACT_WREN, ACT_WRDI} pesr_act_t;

  // One chip-select frame as received
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [2:0]  nbytes;
    logic        aligned;
  } pesr_frame_t;

  // Flags shown to the status logic
  typedef struct packed {
    logic write_enable_latch;
    logic ready_busy_flag;
    logic suspend_flag;
    logic program_suspended_flag;
    logic erase_suspended_flag;
  } pesr_flags_t;

  // Command to the program/erase engine
  typedef struct packed {
    logic        run;
    logic        start;
    pesr_kind_t  kind;
    pesr_span_t  span;
    logic [23:0] addr;
  } pesr_opcmd_t;

  localparam pesr_flags_t FLAGS_RST = '0;
  localparam pesr_opcmd_t OPCMD_RST = '0;

  // True when address a lies in the region of b of the given span
  function automatic logic pesr_hits(input logic [23:0] a,
                                     input logic [23:0] b,
                                     input pesr_span_t  s);
    logic [23:0] m;
    case (s)
      SPAN_PAGE: m = MASK_PAGE;
      SPAN_4K:   m = MASK_4K;
      SPAN_32K:  m = MASK_32K;
      default:   m = MASK_64K;
    endcase
    return ((a ^ b) & m) == 24'h000000;
  endfunction : pesr_hits

endpackage : pesr_pkg

/* pesr_spi_rx.sv */
module pesr_spi_rx
  import pesr_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // Serial pins, asynchronous to clk
  input  wire logic  spi_cs_n,
  input  wire logic  spi_sck,
  input  wire logic  spi_mosi,
  // Frame summary at chip-select release
  output pesr_frame_t frame,
  output logic        frame_v
);

  logic [2:0]  cs_q;
  logic [2:0]  sck_q;
  logic [1:0]  mosi_q;
  logic [2:0]  bit_q;
  logic [2:0]  nbytes_q;
  logic [7:0]  byte_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic [7:0]  shift_in;

  // Two-stage synchronisers; third stage only for edge finding
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cs_q   <= 3'h7;
      sck_q  <= 3'h0;
      mosi_q <= 2'h0;
    end
    else
    begin
      cs_q   <= {cs_q[1:0], spi_cs_n};
      sck_q  <= {sck_q[1:0], spi_sck};
      mosi_q <= {mosi_q[0], spi_mosi};
    end
  end

  // Edges seen from settled stages only
  assign cs_fall  = !cs_q[1] && cs_q[2];
  assign cs_rise  = cs_q[1] && !cs_q[2];
  assign sck_rise = sck_q[1] && !sck_q[2] && !cs_q[1];
  assign shift_in = {byte_q[6:0], mosi_q[1]};

  // Bit and byte counting; bytes past the address are dropped
  always_ff @(posedge clk)
  begin
    if (srst || cs_fall)
    begin
      bit_q    <= 3'h0;
      nbytes_q <= 3'h0;
      byte_q   <= 8'h00;
      op_q     <= 8'h00;
      addr_q   <= 24'h000000;
    end
    else if (sck_rise)
    begin
      bit_q  <= bit_q + 3'h1;
      byte_q <= shift_in;
      if (bit_q == 3'h7)
      begin
        if (nbytes_q == 3'h0)
          op_q <= shift_in;
        else if (nbytes_q < ERASE_MIN_BYTES)
          addr_q <= {addr_q[15:0], shift_in};
        if (nbytes_q != NBYTES_MAX)
          nbytes_q <= nbytes_q + 3'h1;
      end
    end
  end

  // Frame report: a one-cycle pulse when chip select rises
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frame_v <= 1'b0;
      frame   <= '0;
    end
    else
    begin
      frame_v <= cs_rise;
      frame   <= {op_q, addr_q, nbytes_q,
                  (bit_q == 3'h0) && (nbytes_q != 3'h0)};
    end
  end

endmodule : pesr_spi_rx

/* pesr_seq.sv */
// Operation
// - Suspend is one opcode without address; trailing bytes are ignored.
// - Suspend during a whole-array erase does nothing.
// - A program may start while an erase is held suspended.
// - Such a program cannot be suspended; suspend is then ignored.
// - Suspend needs no write enable latch.
// - Valid suspend halts operation, sets its suspend flag, shows ready.
// - Suspend acts only on a whole opcode ending on a byte boundary.
// - Reads inside the suspended page or block give undefined data.
// - Program into an erase-suspended block aborts and clears the latch.
// - Block erase covering the program-suspended page aborts and clears latch.
// - Disallowed commands during suspension are ignored; latch untouched.
// - Permitted commands such as status read still work when suspended.
// - Resume is one opcode without address; trailing bytes are ignored.
// - Resume acts only when suspended and ready; otherwise ignored.
// - Resume needs no write enable latch.
// - Valid resume continues operation, clears its flag, shows busy.
// - Resume acts only on a whole opcode ending on a byte boundary.
// - With both suspended, resume restarts program first, then erase.
// - Suspend is ignored while a resume is still settling.
// - Two whole-array erase opcodes exist; neither is suspendable.
// - Three block erase opcodes choose 4, 32 or 64 kB regions.
module pesr_seq
  import pesr_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = RESUME_SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   srst,
  // Serial pins
  input  wire logic   spi_cs_n,
  input  wire logic   spi_sck,
  input  wire logic   spi_mosi,
  // Program/erase engine
  input  wire logic   eng_done,
  output pesr_opcmd_t eng_cmd,
  // Array read path
  input  wire logic   rd_active,
  input  wire logic [23:0] rd_addr,
  output logic        rd_undef,
  // Status flags and command outcome
  output pesr_flags_t flags,
  output logic        cmd_aborted,
  output logic        cmd_ignored
);

  // Counter is eight bits wide
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
  begin : g_bad_settle
    $error("SETTLE_CYCLES must lie in 1..255");
  end

  pesr_frame_t frame;
  logic        frame_v;
  pesr_act_t   act;
  pesr_state_t state_q;
  pesr_state_t state_d;
  pesr_flags_t flags_d;
  logic [7:0]  settle_q;
  logic [23:0] ps_addr_q;
  logic [23:0] es_addr_q;
  pesr_span_t  es_span_q;
  logic        running;
  logic        susp_any;
  logic        is_berase;
  logic        is_chip;
  pesr_span_t  op_span;

  pesr_spi_rx u_pesr_spi_rx (
    .clk      (clk),
    .srst     (srst),
    .spi_cs_n (spi_cs_n),
    .spi_sck  (spi_sck),
    .spi_mosi (spi_mosi),
    .frame    (frame),
    .frame_v  (frame_v)
  );

  // Opcode classes
  // two chip opcodes
  assign is_chip   = frame.opcode == OPC_CHIP_A || frame.opcode == OPC_CHIP_B;
  assign is_berase = frame.opcode == OPC_ERASE_4K ||
                     frame.opcode == OPC_ERASE_32 ||
                     frame.opcode == OPC_ERASE_64;
  assign op_span   = frame.opcode == OPC_ERASE_4K ? SPAN_4K :
                     frame.opcode == OPC_ERASE_32 ? SPAN_32K : SPAN_64K;
  assign susp_any  = flags.erase_suspended_flag |
                     flags.program_suspended_flag;
  // A finishing operation can no longer be halted
  assign running   = eng_cmd.run && !eng_done;

  // Command decision at the end of each frame
  always_comb
  begin
    act = ACT_NONE;
    if (frame_v)
    begin
      if (!frame.aligned)
        act = ACT_NONE;
      else if (frame.opcode == OPC_SUSPEND)
      begin
        if (running && settle_q == 8'h00 &&
            (state_q == ST_PROG || state_q == ST_ERASE))
          act = ACT_SUSPEND;
      end
      else if (frame.opcode == OPC_RESUME)
      begin
        if (susp_any && !flags.ready_busy_flag)
          act = flags.program_suspended_flag ? ACT_RESUME_P : ACT_RESUME_E;
      end
      else if (flags.ready_busy_flag)
        act = ACT_NONE;
      else if (frame.opcode == OPC_WREN)
        act = ACT_WREN;
      else if (frame.opcode == OPC_WRDI)
        act = ACT_WRDI;
      else if (frame.opcode == OPC_PROGRAM)
      begin
        if (frame.nbytes < PROG_MIN_BYTES || !flags.write_enable_latch)
          act = ACT_NONE;
        else if (flags.program_suspended_flag)
          act = ACT_IGNORE;
        else if (flags.erase_suspended_flag &&
                 pesr_hits(frame.addr, es_addr_q, es_span_q))
          act = ACT_ABORT;
        else
          act = ACT_START_P;
      end
      else if (is_berase)
      begin
        if (frame.nbytes < ERASE_MIN_BYTES || !flags.write_enable_latch)
          act = ACT_NONE;
        else if (flags.program_suspended_flag &&
                 pesr_hits(ps_addr_q, frame.addr, op_span))
          act = ACT_ABORT;
        else if (susp_any)
          act = ACT_IGNORE;
        else
          act = ACT_START_E;
      end
      else if (is_chip)
      begin
        if (!flags.write_enable_latch)
          act = ACT_NONE;
        else if (susp_any)
          act = ACT_IGNORE;
        else
          act = ACT_START_C;
      end
      else if (frame.opcode == OPC_WRSR && susp_any)
        act = ACT_IGNORE;
      // status read left to its own path
      else if (frame.opcode == OPC_RDSR)
        act = ACT_NONE;
    end
  end

  // Next operation state
  always_comb
  begin
    state_d = state_q;
    case (act)
      ACT_SUSPEND:  state_d = ST_IDLE;
      ACT_RESUME_P: state_d = flags.erase_suspended_flag ? ST_PROG_ES
                                                         : ST_PROG;
      ACT_RESUME_E: state_d = ST_ERASE;
      ACT_START_P:  state_d = flags.erase_suspended_flag ? ST_PROG_ES
                                                         : ST_PROG;
      ACT_START_E:  state_d = ST_ERASE;
      ACT_START_C:  state_d = ST_CHIP;
      default:
      begin
        if (eng_done)
          state_d = ST_IDLE;
      end
    endcase
  end

  // Next flag values; busy follows the operation state
  always_comb
  begin
    flags_d = flags;
    case (act)
      ACT_WREN:
        flags_d.write_enable_latch = 1'b1;
      ACT_WRDI, ACT_ABORT, ACT_START_P, ACT_START_E, ACT_START_C:
        flags_d.write_enable_latch = 1'b0;
      ACT_SUSPEND:
      begin
        if (state_q == ST_PROG)
          flags_d.program_suspended_flag = 1'b1;
        else
          flags_d.erase_suspended_flag = 1'b1;
      end
      ACT_RESUME_P:
        flags_d.program_suspended_flag = 1'b0;
      ACT_RESUME_E:
        flags_d.erase_suspended_flag = 1'b0;
      default:
      begin
        if (eng_done)
          flags_d.write_enable_latch = 1'b0;
      end
    endcase
    flags_d.ready_busy_flag = state_d != ST_IDLE;
    flags_d.suspend_flag    = flags_d.erase_suspended_flag |
                              flags_d.program_suspended_flag;
  end

  // State and flags registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      flags   <= FLAGS_RST;
    end
    else
    begin
      state_q <= state_d;
      flags   <= flags_d;
    end
  end

  // Engine command; a resume raises run without start
  always_ff @(posedge clk)
  begin
    if (srst)
      eng_cmd <= OPCMD_RST;
    else
    begin
      eng_cmd.run   <= state_d != ST_IDLE;
      eng_cmd.start <= act == ACT_START_P || act == ACT_START_E ||
                       act == ACT_START_C;
      case (act)
        ACT_START_P:
        begin
          eng_cmd.kind <= KIND_PROG;
          eng_cmd.span <= SPAN_PAGE;
          eng_cmd.addr <= frame.addr;
        end
        ACT_START_E:
        begin
          eng_cmd.kind <= KIND_BERASE;
          eng_cmd.span <= op_span;
          eng_cmd.addr <= frame.addr;
        end
        ACT_START_C:
          eng_cmd.kind <= KIND_CERASE;
        ACT_RESUME_P:
        begin
          eng_cmd.kind <= KIND_PROG;
          eng_cmd.span <= SPAN_PAGE;
          eng_cmd.addr <= ps_addr_q;
        end
        ACT_RESUME_E:
        begin
          eng_cmd.kind <= KIND_BERASE;
          eng_cmd.span <= es_span_q;
          eng_cmd.addr <= es_addr_q;
        end
        default:
        begin
          if (state_d == ST_IDLE)
            eng_cmd.kind <= KIND_NONE;
        end
      endcase
    end
  end

  // Context of the suspended operations
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ps_addr_q <= 24'h000000;
      es_addr_q <= 24'h000000;
      es_span_q <= SPAN_4K;
    end
    else if (act == ACT_SUSPEND)
    begin
      if (state_q == ST_PROG)
        ps_addr_q <= eng_cmd.addr;
      else
      begin
        es_addr_q <= eng_cmd.addr;
        es_span_q <= eng_cmd.span;
      end
    end
  end

  // Settle window after a resume; suspend is ignored inside it
  // settle countdown
  always_ff @(posedge clk)
  begin
    if (srst)
      settle_q <= 8'h00;
    else if (act == ACT_RESUME_P || act == ACT_RESUME_E)
      settle_q <= 8'(SETTLE_CYCLES);
    else if (settle_q != 8'h00)
      settle_q <= settle_q - 8'h01;
  end

  // Read guard; one cycle late, the read path must allow for it
  // suspended region read
  always_ff @(posedge clk)
  begin
    if (srst)
      rd_undef <= 1'b0;
    else
      rd_undef <= rd_active &&
        ((flags.program_suspended_flag &&
          pesr_hits(rd_addr, ps_addr_q, SPAN_PAGE)) ||
         (flags.erase_suspended_flag &&
          pesr_hits(rd_addr, es_addr_q, es_span_q)));
  end

  // Outcome pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_aborted <= 1'b0;
      cmd_ignored <= 1'b0;
    end
    else
    begin
      cmd_aborted <= act == ACT_ABORT;
      cmd_ignored <= act == ACT_IGNORE;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_chip_no_susp: assert property (
    state_q == ST_CHIP |=> !$rose(flags.erase_suspended_flag))
    else $error("chip erase was suspended");

  chk_prog_es_hold: assert property (
    state_q == ST_PROG_ES |=> !$rose(flags.program_suspended_flag))
    else $error("program under erase hold was suspended");

  chk_susp_effect: assert property (
    frame_v && frame.aligned && frame.opcode == OPC_SUSPEND &&
    state_q == ST_ERASE && !eng_done && settle_q == 8'h00
    |=> flags.erase_suspended_flag && !flags.ready_busy_flag &&
        !eng_cmd.run ##1 flags.suspend_flag)
    else $error("suspend did not halt erase");

  chk_misaligned_frame: assert property (
    frame_v && !frame.aligned
    |=> $stable({flags.erase_suspended_flag,
                 flags.program_suspended_flag}))
    else $error("misaligned frame changed suspend flags");

  chk_read_undef: assert property (
    rd_active && flags.program_suspended_flag &&
    pesr_hits(rd_addr, ps_addr_q, SPAN_PAGE) |=> rd_undef)
    else $error("read of held page not flagged");

  chk_prog_abort: assert property (
    frame_v && frame.aligned && frame.opcode == OPC_PROGRAM &&
    frame.nbytes >= PROG_MIN_BYTES && flags.write_enable_latch &&
    !flags.ready_busy_flag && !flags.program_suspended_flag &&
    flags.erase_suspended_flag &&
    pesr_hits(frame.addr, es_addr_q, es_span_q)
    |=> cmd_aborted && !flags.write_enable_latch && !eng_cmd.run)
    else $error("program into held block not aborted");

  chk_wrsr_ignored: assert property (
    frame_v && frame.opcode == OPC_WRSR && flags.suspend_flag
    |=> $stable(flags.write_enable_latch) && !eng_cmd.start)
    else $error("status write acted during suspension");

  chk_resume_gate: assert property (
    $fell(flags.program_suspended_flag) || $fell(flags.erase_suspended_flag)
    |-> $past(frame_v && frame.opcode == OPC_RESUME &&
              !flags.ready_busy_flag))
    else $error("suspend flag cleared without valid resume");

  chk_resume_busy: assert property (
    $fell(flags.program_suspended_flag) || $fell(flags.erase_suspended_flag)
    |-> flags.ready_busy_flag && eng_cmd.run && !eng_cmd.start)
    else $error("resume did not restart operation");

  chk_resume_order: assert property (
    $fell(flags.erase_suspended_flag) |-> !$past(flags.program_suspended_flag))
    else $error("erase resumed before program");

  chk_settle_block: assert property (
    settle_q != 8'h00 |=> !$rose(flags.erase_suspended_flag) &&
                          !$rose(flags.program_suspended_flag))
    else $error("suspend taken while resume settling");

endmodule : pesr_seq

/* pesr_host_model.sv */
module pesr_host_model
(
  // Bench clock, used only to pace the serial pins
  input  wire logic clk,
  // Serial pins toward the device
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: deselected, clock parked low
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_mosi = 1'b0;
  end

  // frames may end off a byte boundary on request
  task automatic send(input logic [39:0] data, input int nbits);
    int i;
    @(negedge clk);
    spi_cs_n = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      spi_mosi = data[39 - i];
      repeat (4) @(negedge clk);
      spi_sck = 1'b1;
      repeat (4) @(negedge clk);
      spi_sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b1;
    // Released line: no stale bit left for the device to trust
    spi_mosi = ~spi_mosi;
    repeat (12) @(negedge clk);
  endtask : send
endmodule : pesr_host_model

/* test_program_erase_suspend_resume.sv */
module test_program_erase_suspend_resume
  import pesr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        spi_cs_n, spi_sck, spi_mosi;
  logic        eng_done = 1'b0;
  logic        rd_active = 1'b0;
  logic [23:0] rd_addr = 24'h000000;
  logic        rd_undef, cmd_aborted, cmd_ignored;
  pesr_opcmd_t eng_cmd;
  pesr_flags_t flags;
  int          fails = 0;
  int          checks_done = 0;
  int          ign_n = 0;
  int          abt_n = 0;
  int          st_n = 0;
  int          cyc = 0;
  logic [7:0]  ops [2] = '{8'h20, 8'hD8};

  // Settle window long enough for a whole frame to land inside it
  pesr_seq #(.SETTLE_CYCLES(200)) u_pesr_seq (
    .clk(clk), .srst(srst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .eng_done(eng_done), .eng_cmd(eng_cmd),
    .rd_active(rd_active), .rd_addr(rd_addr), .rd_undef(rd_undef),
    .flags(flags), .cmd_aborted(cmd_aborted), .cmd_ignored(cmd_ignored));

  pesr_host_model u_pesr_host_model (
    .clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi));

  always #50 clk = ~clk;

  // Pulse counters, so one-cycle outcomes are never missed
  always @(posedge clk)
  begin
    if (cmd_ignored === 1'b1) ign_n++;
    if (cmd_aborted === 1'b1) abt_n++;
    if (eng_cmd.start === 1'b1) st_n++;
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // Flags as {latch, busy, any held, program held, erase held}
  task automatic fl(input logic [4:0] e);
    chk("flags", {19'h0, e}, {19'h0, flags});
  endtask : fl

  task automatic op(input logic [7:0] o);
    u_pesr_host_model.send({o, 32'hA5A5A5A5}, 8);
  endtask : op

  task automatic cmd(input logic [7:0] o, input logic [23:0] a);
    u_pesr_host_model.send({o, a, 8'h3C}, 40);
  endtask : cmd

  task automatic done();
    @(negedge clk);
    eng_done = 1'b1;
    @(negedge clk);
    eng_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask : done

  initial
  begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    fl(5'h00);
    // Nothing running: suspend and resume change nothing
    op(OPC_SUSPEND);
    fl(5'h00);
    op(OPC_RESUME);
    fl(5'h00);
    // 32 kB erase, then a cut suspend and a whole one
    op(OPC_WREN);
    cmd(OPC_ERASE_32, 24'h000000);
    fl(5'h08);
    chk("run", 24'h1, {23'h0, eng_cmd.run});
    chk("start", 24'h1, 24'(st_n));
    chk("kind", 24'(KIND_BERASE), 24'(eng_cmd.kind));
    chk("span", 24'(SPAN_32K), 24'(eng_cmd.span));
    u_pesr_host_model.send({OPC_SUSPEND, 32'h0}, 7);
    fl(5'h08);
    u_pesr_host_model.send({OPC_SUSPEND, 32'hA5}, 16);
    fl(5'h05);
    chk("run", 24'h0, {23'h0, eng_cmd.run});
    // Read walks across the end of the held 32 kB block
    rd_active = 1'b1;
    rd_addr = 24'h007FFF;
    repeat (3) @(negedge clk);
    chk("undef", 24'h1, {23'h0, rd_undef});
    rd_addr = 24'h008000;
    repeat (3) @(negedge clk);
    chk("undef", 24'h0, {23'h0, rd_undef});
    rd_active = 1'b0;
    op(OPC_WREN);
    op(OPC_RDSR);
    fl(5'h15);
    chk("ignored", 24'h0, 24'(ign_n));
    op(OPC_WRDI);
    fl(5'h05);
    op(OPC_WREN);
    u_pesr_host_model.send({OPC_WRSR, 32'h0}, 16);
    fl(5'h15);
    chk("ignored", 24'h1, 24'(ign_n));
    cmd(OPC_PROGRAM, 24'h001010);
    fl(5'h05);
    chk("aborted", 24'h1, 24'(abt_n));
    // Program beside the held block; it cannot be suspended
    op(OPC_WREN);
    cmd(OPC_PROGRAM, 24'h010000);
    fl(5'h0D);
    chk("addr", 24'h010000, eng_cmd.addr);
    chk("start", 24'h2, 24'(st_n));
    op(OPC_SUSPEND);
    fl(5'h0D);
    done();
    fl(5'h05);
    u_pesr_host_model.send({OPC_RESUME, 32'h0}, 12);
    fl(5'h05);
    u_pesr_host_model.send({OPC_RESUME, 32'h5A}, 16);
    fl(5'h08);
    chk("run", 24'h1, {23'h0, eng_cmd.run});
    chk("addr", 24'h000000, eng_cmd.addr);
    chk("start", 24'h2, 24'(st_n));
    op(OPC_SUSPEND);
    fl(5'h08);
    // Host waits out the restart before suspending again
    repeat (200) @(negedge clk);
    op(OPC_SUSPEND);
    fl(5'h05);
    op(OPC_RESUME);
    fl(5'h08);
    done();
    fl(5'h00);
    op(OPC_WREN);
    cmd(OPC_PROGRAM, 24'h004800);
    fl(5'h08);
    op(OPC_SUSPEND);
    fl(5'h06);
    // Read walks off the end of the held page
    rd_active = 1'b1;
    rd_addr = 24'h0048FF;
    repeat (3) @(negedge clk);
    chk("undef", 24'h1, {23'h0, rd_undef});
    rd_addr = 24'h004900;
    repeat (3) @(negedge clk);
    chk("undef", 24'h0, {23'h0, rd_undef});
    rd_active = 1'b0;
    // The 4 kB and 64 kB erases covering the held page must abort
    foreach (ops[i])
    begin
      op(OPC_WREN);
      cmd(ops[i], 24'h004000);
      fl(5'h06);
      chk("aborted", 24'(2 + i), 24'(abt_n));
    end
    op(OPC_RESUME);
    fl(5'h08);
    chk("addr", 24'h004800, eng_cmd.addr);
    done();
    fl(5'h00);
    op(OPC_WREN);
    op(OPC_CHIP_A);
    fl(5'h08);
    chk("kind", 24'(KIND_CERASE), 24'(eng_cmd.kind));
    op(OPC_SUSPEND);
    fl(5'h08);
    done();
    fl(5'h00);
    op(OPC_WREN);
    op(OPC_CHIP_B);
    fl(5'h08);
    op(OPC_SUSPEND);
    fl(5'h08);
    done();
    fl(5'h00);
    chk("start", 24'h5, 24'(st_n));
    give_verdict();
  end
endmodule : test_program_erase_suspend_resume
